// ---- verilog/tcg_pkg.sv ----
// tcg_pkg: shared register map, field layouts and codes of the timer pair
package tcg_pkg;

  // ************************************************************
  // register byte offsets (avalon byte address)
  // ************************************************************
  localparam logic [4:0]  ADR_CTRL  = 5'h00;  // mode, run, enables, clocks
  localparam logic [4:0]  ADR_CMP   = 5'h04;  // three compare values
  localparam logic [4:0]  ADR_CAR   = 5'h08;  // carrier_ctl in low byte
  localparam logic [4:0]  ADR_CNT   = 5'h0C;  // live counts, read only

  // ************************************************************
  // operating modes and count clock codes
  // ************************************************************
  typedef enum logic [1:0] {
    MODE_IDLE = 2'b00,  // both timers held cleared
    MODE_CASC = 2'b01,  // cascaded 16-bit counter / square wave
    MODE_CARR = 2'b10,  // carrier generator
    MODE_PWM  = 2'b11   // upper timer free-running pwm
  } tcg_mode_t;

  localparam logic [2:0]  CS_MAIN   = 3'h0;   // main clock
  localparam logic [2:0]  CS_MAIN4  = 3'h1;   // main clock / 4
  localparam logic [2:0]  CS_EXT    = 3'h2;   // external edge
  localparam logic [2:0]  CS_EXT2   = 3'h3;   // external edge / 2
  localparam logic [2:0]  CS_EXT4   = 3'h4;   // external edge / 4
  localparam logic [2:0]  CS_EXT8   = 3'h5;   // external edge / 8
  localparam logic [1:0]  MAIN4_LAST = 2'h3;  // last state of main divider

  // ************************************************************
  // field layouts
  // ************************************************************
  typedef struct packed {
    logic [12:0] rsv_top;       // reads zero
    logic [2:0]  high_clk_sel;  // upper timer count clock
    logic        rsv_c;         // reads zero
    logic [2:0]  low_clk_sel;   // lower timer count clock
    logic        sel_out_c;     // 1: wave on out_c, 0: on out_b
    logic        out_c_enable;  // out_c pin enable
    logic        out_b_enable;  // out_b pin enable
    logic        out_a_enable;  // out_a pin enable
    logic [1:0]  rsv_b;         // reads zero
    logic        high_run;      // upper timer run
    logic        low_run;       // lower timer run
    logic [1:0]  rsv_a;         // reads zero
    tcg_mode_t   mode;          // operating mode
  } tcg_ctrl_t;

  typedef struct packed {
    logic [7:0]  rsv;           // reads zero
    logic [7:0]  high_compare;  // upper compare
    logic [7:0]  low_alt_compare; // lower alternate compare
    logic [7:0]  low_compare;   // lower compare
  } tcg_cmp_t;

  typedef struct packed {
    logic [4:0]  rsv;           // reads zero
    logic        remote_mode_sel; // 0: carrier pulse output
    logic        nrz_buffer;    // next data level
    logic        nrz_level;     // current data level
  } tcg_car_t;

  localparam logic [31:0] CTRL_WMASK = 32'h0007_7F33;  // writable ctrl bits
  localparam logic [31:0] CMP_WMASK  = 32'h00FF_FFFF;  // writable cmp bits
  localparam logic [31:0] CTRL_RST   = 32'h0000_0000;
  localparam logic [31:0] CMP_RST    = 32'h0000_0000;
  localparam logic [7:0]  CAR_RST    = 8'h00;
  localparam logic [7:0]  CNT_ZERO   = 8'h00;
  localparam logic [7:0]  CNT_TOP    = 8'hFF;
  localparam logic [7:0]  CNT_ONE    = 8'h01;

endpackage : tcg_pkg

// ---- verilog/tcg_tick.sv ----
// tcg_tick: count clock selector producing one-cycle count enables
`timescale 1ns/1ps
`default_nettype none
module tcg_tick (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       nrst,
  // selection and event source
  input  wire logic [2:0] sel,
  input  wire logic       evt_in,
  // count enable
  output logic            tick
);

  logic       evt_prev_ff;  // last sampled event level
  logic [1:0] main_div_ff;  // main clock prescaler
  logic [2:0] ext_div_ff;   // external edge prescaler
  logic       evt_edge;     // valid (rising) edge

  assign evt_edge = evt_in & ~evt_prev_ff;

  // ************************************************************
  // prescalers
  // ************************************************************
  // edge detector on the already synchronous event pin
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      evt_prev_ff <= 1'b0;
    end else begin
      evt_prev_ff <= evt_in;
    end
  end

  // free-running dividers; a code change mid-run may shorten one step
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      main_div_ff <= 2'h0;
      ext_div_ff  <= 3'h0;
    end else begin
      main_div_ff <= main_div_ff + 2'h1;
      if (evt_edge) begin
        ext_div_ff <= ext_div_ff + 3'h1;
      end
    end
  end

  always_comb begin
    unique case (sel)
      tcg_pkg::CS_MAIN:  tick = 1'b1;
      tcg_pkg::CS_MAIN4: tick = (main_div_ff == tcg_pkg::MAIN4_LAST);
      tcg_pkg::CS_EXT:   tick = evt_edge;
      tcg_pkg::CS_EXT2:  tick = evt_edge & ext_div_ff[0];
      tcg_pkg::CS_EXT4:  tick = evt_edge & (&ext_div_ff[1:0]);
      tcg_pkg::CS_EXT8:  tick = evt_edge & (&ext_div_ff);
      default:           tick = 1'b0;  // unused codes never count
    endcase
  end

endmodule : tcg_tick
`default_nettype wire

// ---- verilog/tcg_cnt8.sv ----
// tcg_cnt8: 8-bit up counter with run gate and synchronous clear
`timescale 1ns/1ps
`default_nettype none
module tcg_cnt8 (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       nrst,
  // control
  input  wire logic       run,
  input  wire logic       tick,
  input  wire logic       clr,
  // state
  output logic [7:0]      count
);

  // ************************************************************
  // counter
  // ************************************************************
  // stopped counter holds zero; clear beats the step
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      count <= tcg_pkg::CNT_ZERO;
    end else if (!run || clr) begin
      count <= tcg_pkg::CNT_ZERO;
    end else if (tick) begin
      count <= count + tcg_pkg::CNT_ONE;
    end
  end

endmodule : tcg_cnt8
`default_nettype wire

// ---- verilog/tcg_top.sv ----
// tcg_top: cascadable timer pair with carrier and pwm, avalon slave
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - each valid event edge counts pair up
// - high_count upper byte, low_count lower byte
// - cascade runs and clears on low_run only
// - joint match clears both, low irq only
// - joint match toggles chosen square-wave pin
// - low_run cleared forces square wave low
// - enabled out_b/out_c start low
// - six count clock codes
// - low_compare match toggles, selects alternate
// - alternate match toggles, selects low_compare
// - high match raises irq, reloads nrz_level
// - carrier reaches pin only while nrz_level
// - carrier_ctl bits: mode 2, buffer 1, level 0
// - nrz_level writable only with out_b off
// - nrz_buffer lost on carrier stop
// - pwm match drives out_a low, no clear
// - pwm overflow drives out_a high
module tcg_top (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        nrst,
  // avalon-mm slave
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  // external event pin
  input  wire logic        event_input,
  // timer output pins
  output logic             out_a,
  output logic             out_b,
  output logic             out_c,
  // match pulses
  output logic             low_match_irq,
  output logic             high_match_irq
);

  // ************************************************************
  // declarations
  // ************************************************************
  tcg_pkg::tcg_ctrl_t ctrl_ff;       // control register
  tcg_pkg::tcg_cmp_t  cmp_ff;        // compare values
  tcg_pkg::tcg_car_t  car_ff;        // carrier_ctl
  logic [31:0]        rd_mux;        // read data before register
  logic               acc_wr;        // write taken this edge
  logic [7:0]         low_count;     // lower counter
  logic [7:0]         high_count;    // upper counter
  logic               low_tick;      // lower count enable
  logic               tick1;         // upper selector output
  logic               high_tick;     // upper count enable
  logic               low_run_eff;   // lower counter run
  logic               high_run_eff;  // upper counter run
  logic [7:0]         low_active;    // compare in force below
  logic               alt_sel_ff;    // 1: alternate compare active
  logic               wave_ff;       // square wave / carrier level
  logic               pwm_lvl_ff;    // pwm level
  logic               low_run_d_ff;  // last low_run
  logic               b_en_d_ff;     // last out_b_enable
  logic               c_en_d_ff;     // last out_c_enable
  logic               en_rise;       // selected pin just enabled
  logic               casc_match;    // joint 16-bit match
  logic               car_match;     // carrier lower match
  logic               car_hmatch;    // carrier upper match
  logic               pwm_match;     // pwm compare hit
  logic               pwm_ovf;       // pwm overflow
  logic               pin_sig;       // level for out_b / out_c
  logic               is_casc;
  logic               is_carr;
  logic               is_pwm;

  assign is_casc = (ctrl_ff.mode == tcg_pkg::MODE_CASC);
  assign is_carr = (ctrl_ff.mode == tcg_pkg::MODE_CARR);
  assign is_pwm  = (ctrl_ff.mode == tcg_pkg::MODE_PWM);

  // byte-lane merge under a writable-bit mask
  function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0]  be,
                                           input logic [31:0] wmask);
    logic [31:0] m;
    for (int i = 0; i < 4; i++) begin
      m[i*8 +: 8] = {8{be[i]}};
    end
    m = m & wmask;
    return (old_v & ~m) | (new_v & m);
  endfunction : be_merge

  // ************************************************************
  // avalon slave: one wait cycle, then answer
  // ************************************************************
  assign acc_wr = avs_write & ~avs_waitrequest;

  // waitrequest drops for exactly one edge per request
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
    end
  end

  // unmapped addresses read zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (avs_address)
      tcg_pkg::ADR_CTRL: rd_mux = ctrl_ff;
      tcg_pkg::ADR_CMP:  rd_mux = cmp_ff;
      tcg_pkg::ADR_CAR:  rd_mux = {24'h00_0000, car_ff};
      tcg_pkg::ADR_CNT:  rd_mux = {12'h000, alt_sel_ff, out_c, out_b,
                                   out_a, high_count, low_count};
      default:           rd_mux = 32'h0000_0000;
    endcase
  end

  // read data captured as waitrequest falls
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && avs_waitrequest) begin
      avs_readdata <= rd_mux;
    end
  end

  // control and compare registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_ff <= tcg_pkg::CTRL_RST;
      cmp_ff  <= tcg_pkg::CMP_RST;
    end else if (acc_wr && avs_address == tcg_pkg::ADR_CTRL) begin
      ctrl_ff <= be_merge(ctrl_ff, avs_writedata, avs_byteenable,
                          tcg_pkg::CTRL_WMASK);
    end else if (acc_wr && avs_address == tcg_pkg::ADR_CMP) begin
      cmp_ff <= be_merge(cmp_ff, avs_writedata, avs_byteenable,
                         tcg_pkg::CMP_WMASK);
    end
  end

  // carrier_ctl: hardware reload beats a software write
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      car_ff <= tcg_pkg::CAR_RST;
    end else begin
      if (acc_wr && avs_address == tcg_pkg::ADR_CAR && avs_byteenable[0]) begin
        car_ff.remote_mode_sel <= avs_writedata[2];
        car_ff.nrz_buffer      <= avs_writedata[1];
        if (!ctrl_ff.out_b_enable) begin
          car_ff.nrz_level <= avs_writedata[0];
        end
      end else if (is_carr && low_run_d_ff && !ctrl_ff.low_run) begin
        car_ff.nrz_buffer <= 1'b0;
      end
      if (car_hmatch) begin
        car_ff.nrz_level <= car_ff.nrz_buffer;
      end
    end
  end

  // ************************************************************
  // count clocks and counters
  // ************************************************************
  tcg_tick u_tick_low (
    .clk    (clk),
    .nrst   (nrst),
    .sel    (ctrl_ff.low_clk_sel),
    .evt_in (event_input),
    .tick   (low_tick)
  );

  tcg_tick u_tick_high (
    .clk    (clk),
    .nrst   (nrst),
    .sel    (ctrl_ff.high_clk_sel),
    .evt_in (event_input),
    .tick   (tick1)
  );

  assign low_run_eff  = ctrl_ff.low_run & (ctrl_ff.mode != tcg_pkg::MODE_IDLE);
  assign high_run_eff = is_casc ? ctrl_ff.low_run
                                : (ctrl_ff.high_run & (is_carr | is_pwm));
  // upper byte steps on lower carry
  assign high_tick  = is_casc ? (low_tick & (low_count == tcg_pkg::CNT_TOP))
                              : tick1;
  assign low_active = alt_sel_ff ? cmp_ff.low_alt_compare : cmp_ff.low_compare;

  assign casc_match = is_casc & low_run_eff & low_tick
                    & (low_count == cmp_ff.low_compare)
                    & (high_count == cmp_ff.high_compare);
  assign car_match  = is_carr & low_run_eff & low_tick
                    & (low_count == low_active);
  assign car_hmatch = is_carr & high_run_eff & high_tick
                    & (high_count == cmp_ff.high_compare);
  assign pwm_match  = is_pwm & high_run_eff & high_tick
                    & (high_count == cmp_ff.high_compare);
  assign pwm_ovf    = is_pwm & high_run_eff & high_tick
                    & (high_count == tcg_pkg::CNT_TOP);

  // lower byte counts each selected edge
  tcg_cnt8 u_cnt_low (
    .clk   (clk),
    .nrst  (nrst),
    .run   (low_run_eff),
    .tick  (low_tick),
    .clr   (casc_match | car_match),
    .count (low_count)
  );

  tcg_cnt8 u_cnt_high (
    .clk   (clk),
    .nrst  (nrst),
    .run   (high_run_eff),
    .tick  (high_tick),
    .clr   (casc_match | car_hmatch),
    .count (high_count)
  );

  // ************************************************************
  // match pulses
  // ************************************************************
  // joint match reports on the lower irq only
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      low_match_irq  <= 1'b0;
      high_match_irq <= 1'b0;
    end else begin
      low_match_irq  <= casc_match | car_match;
      high_match_irq <= car_hmatch | pwm_match;
    end
  end

  // ************************************************************
  // wave generation
  // ************************************************************
  assign en_rise = ctrl_ff.sel_out_c ? (ctrl_ff.out_c_enable & ~c_en_d_ff)
                                     : (ctrl_ff.out_b_enable & ~b_en_d_ff);

  // history of run and enables
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      low_run_d_ff <= 1'b0;
      b_en_d_ff    <= 1'b0;
      c_en_d_ff    <= 1'b0;
    end else begin
      low_run_d_ff <= ctrl_ff.low_run;
      b_en_d_ff    <= ctrl_ff.out_b_enable;
      c_en_d_ff    <= ctrl_ff.out_c_enable;
    end
  end

  // square wave / carrier toggle; stop and enable clear it first
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wave_ff <= 1'b0;
    end else if (!ctrl_ff.low_run || en_rise) begin
      wave_ff <= 1'b0;
    end else if (casc_match || car_match) begin
      wave_ff <= ~wave_ff;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      alt_sel_ff <= 1'b0;
    end else if (!low_run_eff || !is_carr) begin
      alt_sel_ff <= 1'b0;
    end else if (car_match) begin
      alt_sel_ff <= ~alt_sel_ff;
    end
  end

  // pwm level; overflow wins when compare is at the top
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pwm_lvl_ff <= 1'b0;
    end else if (!high_run_eff || !is_pwm) begin
      pwm_lvl_ff <= 1'b0;
    end else if (pwm_ovf) begin
      pwm_lvl_ff <= 1'b1;
    end else if (pwm_match) begin
      pwm_lvl_ff <= 1'b0;
    end
  end

  always_comb begin
    pin_sig = 1'b0;
    if (is_casc) begin
      pin_sig = wave_ff;
    end else if (is_carr) begin
      pin_sig = car_ff.remote_mode_sel ? car_ff.nrz_level
                                       : (wave_ff & car_ff.nrz_level);
    end
  end

  // pins registered; out_b/out_c forced low in first enabled cycle
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      out_a <= 1'b0;
      out_b <= 1'b0;
      out_c <= 1'b0;
    end else begin
      // out_a only in pwm mode, cascade cannot use it
      out_a <= ctrl_ff.out_a_enable & is_pwm & pwm_lvl_ff;
      // pin low in its first enabled cycle
      out_b <= ctrl_ff.out_b_enable & b_en_d_ff & ~ctrl_ff.sel_out_c & pin_sig;
      out_c <= ctrl_ff.out_c_enable & c_en_d_ff & ctrl_ff.sel_out_c & pin_sig;
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  casc_clear_a: assert property (@(posedge clk) disable iff (!nrst)
    casc_match |=> (low_count == tcg_pkg::CNT_ZERO)
                   && (high_count == tcg_pkg::CNT_ZERO)
                   && low_match_irq && !high_match_irq)
    else $error("joint match did not clear or raised wrong irq");
  event_step_a: assert property (@(posedge clk) disable iff (!nrst)
    (is_casc && low_run_eff && low_tick && !casc_match)
      |=> low_count == 8'($past(low_count) + tcg_pkg::CNT_ONE))
    else $error("cascade did not count the edge");
  high_ignore_a: assert property (@(posedge clk) disable iff (!nrst)
    (is_casc && !ctrl_ff.low_run) |=> (high_count == tcg_pkg::CNT_ZERO))
    else $error("cascade ran without low_run");
  sq_toggle_a: assert property (@(posedge clk) disable iff (!nrst)
    (casc_match && !en_rise) |=> (wave_ff != $past(wave_ff)))
    else $error("square wave did not toggle");
  sq_stop_a: assert property (@(posedge clk) disable iff (!nrst)
    (is_casc && !ctrl_ff.low_run) |=> !wave_ff ##1 (!out_b && !out_c))
    else $error("square wave not low after stop");
  carrier_alt_a: assert property (@(posedge clk) disable iff (!nrst)
    car_match |=> (alt_sel_ff != $past(alt_sel_ff)) && low_match_irq
                  && (low_count == tcg_pkg::CNT_ZERO))
    else $error("carrier compare did not switch");
  nrz_reload_a: assert property (@(posedge clk) disable iff (!nrst)
    car_hmatch |=> (car_ff.nrz_level == $past(car_ff.nrz_buffer))
                   && high_match_irq)
    else $error("nrz_level not reloaded");
  nrz_lock_a: assert property (@(posedge clk) disable iff (!nrst)
    (ctrl_ff.out_b_enable && !car_hmatch) |=> $stable(car_ff.nrz_level))
    else $error("nrz_level changed while out_b enabled");
  carrier_gate_a: assert property (@(posedge clk) disable iff (!nrst)
    (is_carr && !car_ff.nrz_level) |=> !out_b && !out_c)
    else $error("carrier reached pin while level low");
  pwm_low_a: assert property (@(posedge clk) disable iff (!nrst)
    (pwm_match && !pwm_ovf) |=> !pwm_lvl_ff && high_match_irq
      && high_count == 8'($past(high_count) + tcg_pkg::CNT_ONE))
    else $error("pwm match wrong");
  pwm_ovf_a: assert property (@(posedge clk) disable iff (!nrst)
    pwm_ovf |=> pwm_lvl_ff ##1
      (out_a == ($past(ctrl_ff.out_a_enable) && $past(is_pwm))))
    else $error("pwm overflow did not raise out_a");
  pin_start_a: assert property (@(posedge clk) disable iff (!nrst)
    $rose(ctrl_ff.out_b_enable) |-> !out_b ##1 !out_b)
    else $error("out_b did not start low");

endmodule : tcg_top
`default_nettype wire

// ---- tb/tcg_evt_src.sv ----
// tcg_evt_src: external event source driving the event pin
`timescale 1ns/1ps
`default_nettype none
module tcg_evt_src (
  // clock and reset
  input  wire logic clk,
  input  wire logic nrst,
  // burst request and pin
  input  wire logic go,
  output logic      evt
);
  // one rising edge per two cycles while go, low when idle
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) evt <= 1'b0;
    else evt <= go ? ~evt : 1'b0;
  end
endmodule : tcg_evt_src
`default_nettype wire

// ---- tb/tcg_top_tb_top.sv ----
// tcg_top_tb_top: register-level checks of the timer pair
`timescale 1ns/1ps
`default_nettype none
module tcg_top_tb_top;
  logic        clk, nrst, rd, wr, go, evt, wreq;  // bus, event
  logic        oa, ob, oc, lirq, hirq;            // design outputs
  logic [4:0]  adr;                               // byte address
  logic [31:0] wd, rdat, q;                       // data, last read
  int          err_total, cmp_count, cyc, nl, nh, n;
  // byte lanes all on: whole-word accesses only
  tcg_top uut (.clk(clk), .nrst(nrst), .avs_address(adr),
    .avs_read(rd), .avs_write(wr), .avs_writedata(wd),
    .avs_byteenable(4'hF), .avs_readdata(rdat),
    .avs_waitrequest(wreq), .event_input(evt), .out_a(oa),
    .out_b(ob), .out_c(oc), .low_match_irq(lirq),
    .high_match_irq(hirq));
  tcg_evt_src src (.clk(clk), .nrst(nrst), .go(go), .evt(evt));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // irq pulse counters and hang guard
  always @(posedge clk) begin
    cyc++;
    if (lirq === 1'b1) nl++;
    if (hirq === 1'b1) nh++;
    if (cyc == 20000) begin
      err_total++;
      finish_test();
    end
  end
  // one avalon access, held until waitrequest samples low
  task automatic bus(input logic w_, input logic [4:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    rd  <= ~w_;
    wr  <= w_;
    adr <= a;
    wd  <= d;
    do @(posedge clk); while (wreq !== 1'b0);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic tk(input int k);
    repeat (k) @(posedge clk);
  endtask : tk
  // high time of out_a (sa) or out_b; skips a pulse in progress
  task automatic width(input bit sa, input int lim);
    n = 0;
    for (int i = 0; i < lim && (sa ? oa : ob) !== 1'b0; i++) tk(1);
    for (int i = 0; i < lim && (sa ? oa : ob) !== 1'b1; i++) tk(1);
    while (n < lim && (sa ? oa : ob) === 1'b1) begin
      tk(1);
      n++;
    end
  endtask : width
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : finish_test
  initial begin
    nrst = 1'b0;
    rd = 1'b0;
    wr = 1'b0;
    go = 1'b0;
    adr = 5'h00;
    wd = 32'h0;
    tk(12);
    nrst <= 1'b1;
    // reset values; 0x10 is unmapped and reads zero
    for (int i = 0; i < 5; i++) begin
      bus(1'b0, 5'(4 * i), 32'h0);
      chk(q, 32'h0);
    end
    $display("test reset done");
    // cascade on events, high_run off, out_a kept disabled
    bus(1'b1, tcg_pkg::ADR_CMP, 32'h0001_0002);
    bus(1'b1, tcg_pkg::ADR_CTRL, 32'h0000_2011);
    go <= 1'b1;
    tk(516);
    go <= 1'b0;
    tk(8);
    bus(1'b0, tcg_pkg::ADR_CNT, 32'h0);
    chk(q & 32'hFFFF, 32'h0102);
    chk(32'(nl), 32'h0);
    go <= 1'b1;
    tk(2);
    go <= 1'b0;
    tk(8);
    bus(1'b0, tcg_pkg::ADR_CNT, 32'h0);
    chk(q & 32'hFFFF, 32'h0);
    chk(32'(nl * 16 + nh), 32'h10);
    $display("test cascade count done");
    // square wave, lc=3: four cycles per level
    bus(1'b1, tcg_pkg::ADR_CTRL, 32'h0);
    bus(1'b1, tcg_pkg::ADR_CMP, 32'h0000_0003);
    bus(1'b1, tcg_pkg::ADR_CTRL, 32'h0000_0201);
    tk(2);
    chk(32'(ob), 32'h0);
    bus(1'b1, tcg_pkg::ADR_CTRL, 32'h0000_0211);
    width(1'b0, 40);
    chk(32'(n), 32'h4);
    bus(1'b1, tcg_pkg::ADR_CTRL, 32'h0000_0201);
    tk(3);
    chk(32'(ob), 32'h0);
    // out_c on main clock / 4: sixteen cycles per level
    bus(1'b1, tcg_pkg::ADR_CTRL, 32'h0000_1C11);
    tk(2);
    n = 0;
    repeat (64) begin
      tk(1);
      if (oc === 1'b1) n++;
    end
    chk(32'(n), 32'h20);
    $display("test square wave done");
    // carrier lc=1 alt=3 hc=0x28, buffer 1 and level 0 preset
    bus(1'b1, tcg_pkg::ADR_CTRL, 32'h0);
    bus(1'b1, tcg_pkg::ADR_CMP, 32'h0028_0301);
    bus(1'b1, tcg_pkg::ADR_CAR, 32'h2);
    bus(1'b1, tcg_pkg::ADR_CTRL, 32'h0000_0202);
    bus(1'b1, tcg_pkg::ADR_CAR, 32'h3);
    bus(1'b0, tcg_pkg::ADR_CAR, 32'h0);
    chk(q, 32'h2);
    nh = 0;
    bus(1'b1, tcg_pkg::ADR_CTRL, 32'h0000_0232);
    n = 0;
    repeat (30) begin
      tk(1);
      if (ob === 1'b1) n++;
    end
    chk(32'(n), 32'h0);
    width(1'b0, 80);
    width(1'b0, 80);
    chk(32'(n), 32'h4);
    chk(32'(nh > 0), 32'h1);
    $display("test carrier done");
    // pwm: high from overflow until match at 0x40
    bus(1'b1, tcg_pkg::ADR_CTRL, 32'h0);
    bus(1'b1, tcg_pkg::ADR_CMP, 32'h0040_0000);
    bus(1'b1, tcg_pkg::ADR_CTRL, 32'h0000_0123);
    nh = 0;
    width(1'b1, 600);
    chk(32'(n), 32'h41);
    chk(32'(nh > 0), 32'h1);
    $display("test pwm done");
    finish_test();
  end
endmodule : tcg_top_tb_top
`default_nettype wire
